// >>> design/csfr_pkg.sv
// Package of addresses, field positions and reset values for the special function registers
package csfr_pkg;
  localparam logic [7:0] ADDR_INDIRECT_PORT_ZERO = 8'h00;
  localparam logic [7:0] ADDR_POINTER_ZERO = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_PORT_ONE = 8'h02;
  localparam logic [7:0] ADDR_POINTER_ONE = 8'h03;
  localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
  localparam logic [7:0] ADDR_WORKING_REGISTER = 8'h05;
  localparam logic [7:0] ADDR_PROG_COUNTER_LOW = 8'h06;
  localparam logic [7:0] ADDR_TABLE_POINTER_LOW = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH_RESULT = 8'h08;
  localparam logic [7:0] ADDR_TABLE_POINTER_HIGH = 8'h09;
  localparam logic [7:0] ADDR_FLAG_REGISTER = 8'h0A;
  localparam logic [7:0] SFR_AREA_END = 8'h3F;
  localparam int FLAG_CARRY_POS = 0;
  localparam int FLAG_NIBBLE_POS = 1;
  localparam int FLAG_ZERO_POS = 2;
  localparam int FLAG_SIGNED_WRAP_POS = 3;
  localparam int FLAG_SLEEP_ENTRY_POS = 4;
  localparam int FLAG_WATCHDOG_EXPIRY_POS = 5;
  localparam int BANK_SELECT_BIT_POS = 0;
  localparam logic [7:0] BANK_SELECT_RESET = 8'h00;
  localparam logic [7:0] FLAG_REGISTER_RESET = 8'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] INDIRECT_READ_VALUE = 8'h00;
  localparam logic [3:0] ARITH_FLAG_MASK = 4'hF;
  // ALU operations the execution unit can request
  typedef enum logic [3:0] {
    CSFR_OP_NONE, CSFR_OP_ADD, CSFR_OP_ADDC, CSFR_OP_SUB, CSFR_OP_SUBC,
    CSFR_OP_AND, CSFR_OP_OR, CSFR_OP_XOR, CSFR_OP_RLC, CSFR_OP_RRC, CSFR_OP_PASS
  } csfr_op_t;
endpackage

// >>> design/csfr_core.sv
// Special function register logic: pointers, bank select, working register, counter low, table, flags
`timescale 1ns/1ps
module csfr_core #(
  parameter int PC_WIDTH = 12
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wdt_sleep_reset,
  input wire logic power_up_reset,
  // Data memory access from the execution unit
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  // ALU request
  input wire logic [3:0] alu_op,
  input wire logic [7:0] alu_operand,
  input wire logic alu_to_working,
  // System events
  input wire logic watchdog_clear_instruction,
  input wire logic sleep_instruction,
  input wire logic watchdog_timeout,
  // Table read request and program memory answer
  input wire logic table_read,
  input wire logic [15:0] prog_word,
  // Program counter advance from the fetch unit
  input wire logic pc_advance,
  // Access results
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic mem_valid,
  output logic mem_write,
  output logic [8:0] mem_addr,
  output logic [7:0] mem_wdata,
  // Core state
  output logic [7:0] working_register,
  output logic [7:0] flag_register,
  output logic [PC_WIDTH-1:0] prog_counter,
  output logic dummy_cycle,
  output logic [15:0] table_addr,
  output logic [7:0] table_low_byte,
  output logic table_low_valid
);
  typedef struct packed {
    logic [7:0] pointer_zero;
    logic [7:0] pointer_one;
    logic bank_select_bit;
    logic [7:0] working_register;
    logic [PC_WIDTH-1:0] prog_counter;
    logic dummy_cycle;
    logic [7:0] table_pointer_low;
    logic [7:0] table_pointer_high;
    logic [7:0] table_high_result;
    logic [3:0] arith_flags;
    logic sleep_entry_flag;
    logic watchdog_expiry_flag;
    logic [7:0] rd_data;
    logic rd_valid;
    logic mem_valid;
    logic mem_write;
    logic [8:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] table_low_byte;
    logic table_low_valid;
  } csfr_state_t;

  csfr_state_t cur;
  csfr_state_t next_cur;

  // Address decode
  logic [7:0] eff_addr;
  logic eff_bank;
  logic indirect_zero;
  logic indirect_one;
  logic nested_indirect;
  logic sfr_hit;
  logic [7:0] sfr_rdata;

  // ALU datapath
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic cin;
  logic is_sub;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_ac;
  logic alu_ov;
  logic alu_arith;

  // Status byte as software sees it
  logic [7:0] flag_read;

  always_comb begin
    flag_read = 8'h00;
    flag_read[csfr_pkg::FLAG_WATCHDOG_EXPIRY_POS] = cur.watchdog_expiry_flag;
    flag_read[csfr_pkg::FLAG_SLEEP_ENTRY_POS] = cur.sleep_entry_flag;
    flag_read[3:0] = cur.arith_flags;
  end

  // Address resolution
  always_comb begin
    indirect_zero = (acc_addr == csfr_pkg::ADDR_INDIRECT_PORT_ZERO);
    indirect_one = (acc_addr == csfr_pkg::ADDR_INDIRECT_PORT_ONE);
    eff_addr = acc_addr;
    eff_bank = 1'b0;
    if (indirect_zero) begin
      eff_addr = cur.pointer_zero;
      eff_bank = 1'b0;
    end else if (indirect_one) begin
      eff_addr = cur.pointer_one;
      eff_bank = cur.bank_select_bit;
    end
    // Peripheral registers exist once, whatever the bank
    if (eff_addr <= csfr_pkg::SFR_AREA_END) begin
      eff_bank = 1'b0;
    end

    nested_indirect = (indirect_zero || indirect_one) &&
                      (eff_addr == csfr_pkg::ADDR_INDIRECT_PORT_ZERO ||
                       eff_addr == csfr_pkg::ADDR_INDIRECT_PORT_ONE);

    // Bank bit ignored for the special area
    sfr_hit = (eff_addr <= csfr_pkg::ADDR_FLAG_REGISTER);
  end

  // Readback of the registers held here
  always_comb begin
    case (eff_addr)
      csfr_pkg::ADDR_POINTER_ZERO: sfr_rdata = cur.pointer_zero;
      csfr_pkg::ADDR_POINTER_ONE: sfr_rdata = cur.pointer_one;
      csfr_pkg::ADDR_BANK_SELECT: sfr_rdata = {7'h00, cur.bank_select_bit};
      csfr_pkg::ADDR_WORKING_REGISTER: sfr_rdata = cur.working_register;
      csfr_pkg::ADDR_PROG_COUNTER_LOW: sfr_rdata = cur.prog_counter[7:0];
      csfr_pkg::ADDR_TABLE_POINTER_LOW: sfr_rdata = cur.table_pointer_low;
      csfr_pkg::ADDR_TABLE_HIGH_RESULT: sfr_rdata = cur.table_high_result;
      csfr_pkg::ADDR_TABLE_POINTER_HIGH: sfr_rdata = cur.table_pointer_high;
      csfr_pkg::ADDR_FLAG_REGISTER: sfr_rdata = flag_read;
      default: sfr_rdata = csfr_pkg::INDIRECT_READ_VALUE;
    endcase
  end

  // ALU with flag generation
  always_comb begin
    op_a = cur.working_register;
    op_b = alu_operand;
    is_sub = (alu_op == 4'(csfr_pkg::CSFR_OP_SUB)) || (alu_op == 4'(csfr_pkg::CSFR_OP_SUBC));
    cin = 1'b0;
    if (alu_op == 4'(csfr_pkg::CSFR_OP_ADDC) || alu_op == 4'(csfr_pkg::CSFR_OP_SUBC)) begin
      cin = cur.arith_flags[csfr_pkg::FLAG_CARRY_POS];
    end else if (alu_op == 4'(csfr_pkg::CSFR_OP_SUB)) begin
      cin = 1'b1;
    end
    if (is_sub) begin
      op_b = ~alu_operand;
    end
    // Carry out on subtract means no borrow
    sum9 = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
    sum5 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
    alu_c = sum9[8];
    alu_ac = sum5[4];
    alu_ov = (op_a[7] ~^ op_b[7]) & (op_a[7] ^ sum9[7]);
    alu_arith = 1'b1;
    alu_res = sum9[7:0];
    case (alu_op)
      4'(csfr_pkg::CSFR_OP_AND): alu_res = op_a & alu_operand;
      4'(csfr_pkg::CSFR_OP_OR): alu_res = op_a | alu_operand;
      4'(csfr_pkg::CSFR_OP_XOR): alu_res = op_a ^ alu_operand;
      4'(csfr_pkg::CSFR_OP_RLC): begin
        alu_res = {op_a[6:0], cur.arith_flags[csfr_pkg::FLAG_CARRY_POS]};
        alu_c = op_a[7];
      end
      4'(csfr_pkg::CSFR_OP_RRC): begin
        alu_res = {cur.arith_flags[csfr_pkg::FLAG_CARRY_POS], op_a[7:1]};
        alu_c = op_a[0];
      end
      4'(csfr_pkg::CSFR_OP_PASS): alu_res = alu_operand;
      default: alu_res = sum9[7:0];
    endcase
    if (alu_op == 4'(csfr_pkg::CSFR_OP_AND) || alu_op == 4'(csfr_pkg::CSFR_OP_OR) ||
        alu_op == 4'(csfr_pkg::CSFR_OP_XOR) || alu_op == 4'(csfr_pkg::CSFR_OP_PASS)) begin
      alu_arith = 1'b0;
    end
  end

  // Next state; later blocks override earlier ones
  always_comb begin
    next_cur = cur;
    next_cur.rd_valid = 1'b0;
    next_cur.mem_valid = 1'b0;
    next_cur.mem_write = 1'b0;
    next_cur.table_low_valid = 1'b0;
    next_cur.dummy_cycle = 1'b0;
    // Flushed word does not advance the counter
    if (pc_advance && !cur.dummy_cycle) begin
      next_cur.prog_counter = cur.prog_counter + PC_WIDTH'(1);
    end

    // Register or memory access
    if (acc_valid) begin
      if (nested_indirect) begin
        if (!acc_write) begin
          next_cur.rd_data = csfr_pkg::INDIRECT_READ_VALUE;
          next_cur.rd_valid = 1'b1;
        end
      end else if (sfr_hit) begin
        if (!acc_write) begin
          next_cur.rd_data = sfr_rdata;
          next_cur.rd_valid = 1'b1;
        end else begin
          case (eff_addr)
            csfr_pkg::ADDR_POINTER_ZERO: next_cur.pointer_zero = acc_wdata;
            csfr_pkg::ADDR_POINTER_ONE: next_cur.pointer_one = acc_wdata;
            csfr_pkg::ADDR_BANK_SELECT:
              next_cur.bank_select_bit = acc_wdata[csfr_pkg::BANK_SELECT_BIT_POS];
            csfr_pkg::ADDR_WORKING_REGISTER: next_cur.working_register = acc_wdata;
            csfr_pkg::ADDR_PROG_COUNTER_LOW: begin
              next_cur.prog_counter = {cur.prog_counter[PC_WIDTH-1:8], acc_wdata};
              next_cur.dummy_cycle = 1'b1;
            end
            csfr_pkg::ADDR_TABLE_POINTER_LOW: next_cur.table_pointer_low = acc_wdata;
            csfr_pkg::ADDR_TABLE_HIGH_RESULT: next_cur.table_high_result = acc_wdata;
            csfr_pkg::ADDR_TABLE_POINTER_HIGH: next_cur.table_pointer_high = acc_wdata;
            csfr_pkg::ADDR_FLAG_REGISTER:
              next_cur.arith_flags = acc_wdata[3:0] & csfr_pkg::ARITH_FLAG_MASK;
            default: next_cur.rd_valid = 1'b0;
          endcase
        end
      end else begin
        // Above the flag register address: pass to the data memory array
        next_cur.mem_valid = 1'b1;
        next_cur.mem_write = acc_write;
        next_cur.mem_addr = {eff_bank, eff_addr};
        next_cur.mem_wdata = acc_wdata;
      end
    end

    // ALU result; no flag stacking on calls or interrupts
    if (alu_op != 4'(csfr_pkg::CSFR_OP_NONE)) begin
      if (alu_to_working) begin
        next_cur.working_register = alu_res;
      end
      next_cur.arith_flags[csfr_pkg::FLAG_ZERO_POS] = (alu_res == 8'h00);
      next_cur.arith_flags[csfr_pkg::FLAG_CARRY_POS] = (alu_arith || alu_op == 4'(csfr_pkg::CSFR_OP_RLC) ||
        alu_op == 4'(csfr_pkg::CSFR_OP_RRC)) ? alu_c : cur.arith_flags[csfr_pkg::FLAG_CARRY_POS];
      // Logic ops and rotates leave nibble and wrap alone
      if (alu_arith && alu_op != 4'(csfr_pkg::CSFR_OP_RLC) && alu_op != 4'(csfr_pkg::CSFR_OP_RRC)) begin
        next_cur.arith_flags[csfr_pkg::FLAG_NIBBLE_POS] = alu_ac;
        next_cur.arith_flags[csfr_pkg::FLAG_SIGNED_WRAP_POS] = alu_ov;
      end
    end

    // Table read, word answer taken the same cycle
    if (table_read) begin
      next_cur.table_high_result = prog_word[15:8];
      next_cur.table_low_byte = prog_word[7:0];
      next_cur.table_low_valid = 1'b1;
    end

    // Expiry flag: a timeout beats the clears
    if (sleep_instruction || watchdog_clear_instruction) begin
      next_cur.watchdog_expiry_flag = 1'b0;
    end
    if (watchdog_timeout) begin
      next_cur.watchdog_expiry_flag = 1'b1;
    end
    // Sleep flag: entering sleep beats the clear
    if (watchdog_clear_instruction) begin
      next_cur.sleep_entry_flag = 1'b0;
    end
    if (sleep_instruction) begin
      next_cur.sleep_entry_flag = 1'b1;
    end
    if (power_up_reset) begin
      next_cur.watchdog_expiry_flag = 1'b0;
      next_cur.sleep_entry_flag = 1'b0;
    end

    // Synchronous power-up and watchdog sleep resets: bank kept only for watchdog sleep wakeup
    if (power_up_reset) begin
      next_cur.bank_select_bit = 1'b0;
    end
    if (wdt_sleep_reset) begin
      next_cur.bank_select_bit = cur.bank_select_bit;
    end
  end

  // Async reset is a non-watchdog reset, so bank returns to 0
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
      cur.pointer_zero <= csfr_pkg::POINTER_RESET;
      cur.pointer_one <= csfr_pkg::POINTER_RESET;
      cur.arith_flags <= csfr_pkg::FLAG_REGISTER_RESET[3:0];
      cur.sleep_entry_flag <= csfr_pkg::FLAG_REGISTER_RESET[csfr_pkg::FLAG_SLEEP_ENTRY_POS];
      cur.watchdog_expiry_flag <= csfr_pkg::FLAG_REGISTER_RESET[csfr_pkg::FLAG_WATCHDOG_EXPIRY_POS];
      cur.bank_select_bit <= csfr_pkg::BANK_SELECT_RESET[0];
    end else begin
      cur <= next_cur;
    end
  end

  assign rd_data = cur.rd_data;
  assign rd_valid = cur.rd_valid;
  assign mem_valid = cur.mem_valid;
  assign mem_write = cur.mem_write;
  assign mem_addr = cur.mem_addr;
  assign mem_wdata = cur.mem_wdata;
  assign working_register = cur.working_register;
  assign flag_register = flag_read;
  assign prog_counter = cur.prog_counter;
  assign dummy_cycle = cur.dummy_cycle;
  assign table_addr = {cur.table_pointer_high, cur.table_pointer_low};
  assign table_low_byte = cur.table_low_byte;
  assign table_low_valid = cur.table_low_valid;
endmodule

// >>> testbench/csfr_core_properties.sv
// Concurrent checks on the special function register block ports
`timescale 1ns/1ps
module csfr_core_properties #(
  parameter int PC_WIDTH = 12
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic power_up_reset,
  // Requests
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [3:0] alu_op,
  input wire logic alu_to_working,
  input wire logic watchdog_clear_instruction,
  input wire logic sleep_instruction,
  input wire logic watchdog_timeout,
  input wire logic table_read,
  input wire logic [15:0] prog_word,
  // Results
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [8:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] working_register,
  input wire logic [7:0] flag_register,
  input wire logic [PC_WIDTH-1:0] prog_counter,
  input wire logic dummy_cycle,
  input wire logic [7:0] table_low_byte,
  input wire logic table_low_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence pcl_write_s;
    acc_valid && acc_write && acc_addr == csfr_pkg::ADDR_PROG_COUNTER_LOW;
  endsequence
  sequence fwd_s;
    acc_valid && acc_addr > csfr_pkg::ADDR_FLAG_REGISTER;
  endsequence
  chk_direct_bank_zero: assert property (fwd_s |=> mem_valid && mem_addr == {1'b0, $past(acc_addr)})
    else $error("direct access left bank 0");
  chk_fwd_write_data: assert property (fwd_s ##0 acc_write |=> mem_write && mem_wdata == $past(acc_wdata))
    else $error("forwarded write data wrong");
  chk_mem_has_cause: assert property (mem_valid |-> $past(acc_valid))
    else $error("memory access without request");
  chk_pcl_jump_page: assert property (pcl_write_s |=> prog_counter[7:0] == $past(acc_wdata)
    && prog_counter[PC_WIDTH-1:8] == $past(prog_counter[PC_WIDTH-1:8]))
    else $error("counter low write jumped wrongly");
  chk_pcl_dummy: assert property (pcl_write_s |=> dummy_cycle)
    else $error("no dummy cycle after counter write");
  chk_dummy_cause: assert property (dummy_cycle |-> $past(acc_valid) && $past(acc_write)
    && $past(acc_addr) == csfr_pkg::ADDR_PROG_COUNTER_LOW)
    else $error("dummy cycle without counter write");
  chk_timeout_sets: assert property (watchdog_timeout && !power_up_reset |=> flag_register[5])
    else $error("expiry flag not set");
  chk_expiry_clears: assert property ((watchdog_clear_instruction || sleep_instruction)
    && !watchdog_timeout |=> !flag_register[5])
    else $error("expiry flag not cleared");
  chk_sleep_sets: assert property (sleep_instruction && !watchdog_clear_instruction
    && !power_up_reset |=> flag_register[4])
    else $error("sleep flag not set");
  chk_sys_flags_hold: assert property (!(watchdog_timeout || watchdog_clear_instruction
    || sleep_instruction || power_up_reset) |=> $stable(flag_register[5:4]))
    else $error("system flags moved without event");
  chk_power_up_clear: assert property (power_up_reset |=> flag_register[5:4] == 2'b00)
    else $error("power-up left system flags set");
  chk_top_bits_zero: assert property (flag_register[7:6] == 2'b00)
    else $error("unused flag bits not zero");
  chk_table_low_out: assert property (table_read |=> table_low_valid
    && table_low_byte == $past(prog_word[7:0]))
    else $error("table low byte wrong");
  chk_add_zero: assert property (alu_op == csfr_pkg::CSFR_OP_ADD && alu_to_working
    |=> flag_register[2] == (working_register == 8'h00))
    else $error("zero flag disagrees with result");
endmodule

// >>> testbench/csfr_exec_model.sv
// Program memory side of the execution unit: answers table fetches
`timescale 1ns/1ps
module csfr_exec_model (
  // Table address in, program word out
  input wire logic [15:0] table_addr,
  output logic [15:0] prog_word
);
  // Scrambled so high and low bytes never echo the pointers
  assign prog_word = {table_addr[7:0] ^ 8'hC3, table_addr[15:8] ^ 8'h5A};
endmodule

// >>> testbench/csfr_core_bench.sv
// Self-checking bench for the special function register block
`timescale 1ns/1ps
module csfr_core_bench;
  logic clk_sys, rstn, wdt_sleep_reset, power_up_reset, acc_valid, acc_write, alu_to_working;
  logic watchdog_clear_instruction, sleep_instruction, watchdog_timeout, table_read, pc_advance;
  logic [7:0] acc_addr, acc_wdata, alu_operand, rd_data, mem_wdata, working_register, flag_register;
  logic [7:0] table_low_byte;
  logic [3:0] alu_op;
  logic [15:0] prog_word, table_addr;
  logic rd_valid, mem_valid, mem_write, dummy_cycle, table_low_valid;
  logic [8:0] mem_addr;
  logic [11:0] prog_counter;
  int mismatches, compares;
  // op, flags in, working, operand, result, flags out
  logic [35:0] alu_tbl [12] = '{36'h1080800_0D, 36'h100F011_02, 36'h210F001_02, 36'h3005050_07,
    36'h308001_7F9, 36'h4105050_07, 36'h5BF00F0_0F, 36'h6000000_04, 36'h745AA5F_F0, 36'h8080000_05,
    36'h9101008_01, 36'hA012000_04};
  csfr_core #(.PC_WIDTH(12)) dut (.clk_sys, .rstn, .wdt_sleep_reset, .power_up_reset, .acc_valid,
    .acc_write, .acc_addr, .acc_wdata, .alu_op, .alu_operand, .alu_to_working, .watchdog_clear_instruction,
    .sleep_instruction, .watchdog_timeout, .table_read, .prog_word, .pc_advance, .rd_data, .rd_valid,
    .mem_valid, .mem_write, .mem_addr, .mem_wdata, .working_register, .flag_register, .prog_counter,
    .dummy_cycle, .table_addr, .table_low_byte, .table_low_valid);
  csfr_exec_model partner (.table_addr, .prog_word);
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    acc_valid = 1'b1;
    acc_write = w;
    acc_addr = a;
    acc_wdata = d;
    @(negedge clk_sys);
    acc_valid = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("rd_data", {8'h00, e}, {8'h00, rd_data});
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {rstn, wdt_sleep_reset, power_up_reset, acc_valid, acc_write, alu_to_working, table_read} = 7'h00;
    {watchdog_clear_instruction, sleep_instruction, watchdog_timeout, pc_advance} = 4'h0;
    {acc_addr, acc_wdata, alu_operand, alu_op} = 28'h0000000;
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    chk("flags", 16'h0000, {8'h00, flag_register});
    rd(8'h04, 8'h00);
    acc(1'b1, 8'h04, 8'hFF);
    rd(8'h04, 8'h01);
    acc(1'b1, 8'h01, 8'h5A);
    rd(8'h01, 8'h5A);
    acc(1'b1, 8'h03, 8'h40);
    acc(1'b1, 8'h02, 8'h77);
    chk("mem", 16'h0377, {6'h00, mem_valid, mem_write, mem_wdata});
    chk("mem_addr", 16'h0140, {7'h00, mem_addr});
    acc(1'b1, 8'h03, 8'h20);
    acc(1'b1, 8'h02, 8'h66);
    chk("mem_addr", 16'h0020, {7'h00, mem_addr});
    acc(1'b1, 8'h01, 8'h40);
    acc(1'b1, 8'h00, 8'h11);
    chk("mem_addr", 16'h0040, {7'h00, mem_addr});
    acc(1'b1, 8'h50, 8'h22);
    chk("mem_addr", 16'h0050, {7'h00, mem_addr});
    acc(1'b1, 8'h03, 8'h00);
    rd(8'h02, 8'h00);
    acc(1'b1, 8'h01, 8'h02);
    acc(1'b1, 8'h00, 8'h55);
    chk("mem_valid", 16'h0000, {15'h0000, mem_valid});
    pulse(wdt_sleep_reset);
    rd(8'h04, 8'h01);
    pulse(power_up_reset);
    rd(8'h04, 8'h00);
    acc(1'b1, 8'h0A, 8'hFF);
    chk("flags", 16'h000F, {8'h00, flag_register});
    pulse(sleep_instruction);
    chk("sys_flags", 16'h0001, {14'h0000, flag_register[5:4]});
    pulse(watchdog_timeout);
    chk("sys_flags", 16'h0003, {14'h0000, flag_register[5:4]});
    pulse(watchdog_clear_instruction);
    chk("sys_flags", 16'h0000, {14'h0000, flag_register[5:4]});
    pulse(watchdog_timeout);
    pulse(sleep_instruction);
    chk("sys_flags", 16'h0001, {14'h0000, flag_register[5:4]});
    for (int i = 0; i < 12; i++) begin
      acc(1'b1, 8'h0A, {4'h0, alu_tbl[i][31:28]});
      acc(1'b1, 8'h05, alu_tbl[i][27:20]);
      alu_op = alu_tbl[i][35:32];
      alu_operand = alu_tbl[i][19:12];
      alu_to_working = 1'b1;
      @(negedge clk_sys);
      alu_op = 4'h0;
      alu_to_working = 1'b0;
      chk("working", {8'h00, alu_tbl[i][11:4]}, {8'h00, working_register});
      chk("arith_flags", {12'h000, alu_tbl[i][3:0]}, {12'h000, flag_register[3:0]});
    end
    pc_advance = 1'b1;
    repeat (260) @(negedge clk_sys);
    pc_advance = 1'b0;
    chk("pc", 16'h0104, {4'h0, prog_counter});
    acc(1'b1, 8'h06, 8'h33);
    chk("pc", 16'h0133, {4'h0, prog_counter});
    chk("dummy", 16'h0001, {15'h0000, dummy_cycle});
    pc_advance = 1'b1;
    @(negedge clk_sys);
    pc_advance = 1'b0;
    chk("pc", 16'h0133, {4'h0, prog_counter});
    chk("dummy", 16'h0000, {15'h0000, dummy_cycle});
    acc(1'b1, 8'h07, 8'h34);
    acc(1'b1, 8'h09, 8'h12);
    chk("table_addr", 16'h1234, table_addr);
    pulse(table_read);
    chk("table_low", 16'h0148, {7'h00, table_low_valid, table_low_byte});
    rd(8'h08, 8'hF7);
    wrap_up();
  end
endmodule
bind csfr_core csfr_core_properties #(.PC_WIDTH(PC_WIDTH)) u_props (.clk_sys, .rstn, .power_up_reset,
  .acc_valid, .acc_write, .acc_addr, .acc_wdata, .alu_op, .alu_to_working, .watchdog_clear_instruction,
  .sleep_instruction, .watchdog_timeout, .table_read, .prog_word, .mem_valid, .mem_write, .mem_addr,
  .mem_wdata, .working_register, .flag_register, .prog_counter, .dummy_cycle, .table_low_byte,
  .table_low_valid);
